// ===== move_exec_pkg.sv
// Shared constants, register map and phase encoding for the move executor
package move_exec_pkg;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam int unsigned INSTR_W      = 14;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned FADDR_W      = 7;
    localparam int unsigned FILE_DEPTH   = 128;
    localparam int unsigned DEST_BIT     = 7;
    localparam logic [5:0]  COPY_PATTERN  = 6'h08;
    localparam logic [6:0]  STORE_PATTERN = 7'h01;
    localparam logic [3:0]  LOAD_PATTERN  = 4'hC;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ------------------------------------------------------------------
    localparam logic [31:0] OFS_INSTR    = 32'h0000_0000;
    localparam logic [31:0] OFS_ACC      = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS   = 32'h0000_0008;
    localparam logic [31:0] OFS_FPTR     = 32'h0000_000C;
    localparam logic [31:0] OFS_FDATA    = 32'h0000_0010;
    localparam int unsigned ZERO_BIT     = 0;
    localparam int unsigned BUSY_BIT     = 1;
    localparam int unsigned UNSUP_BIT    = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [13:0] RST_INSTR    = 14'h0000;
    localparam logic [7:0]  RST_ACC      = 8'h00;
    localparam logic        RST_ZERO     = 1'b0;
    localparam logic [6:0]  RST_FPTR     = 7'h00;

    // ------------------------------------------------------------------
    // Execution phases, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_Q1   = 5'h02,
        PH_Q2   = 5'h04,
        PH_Q3   = 5'h08,
        PH_Q4   = 5'h10
    } phase_t;

endpackage

// ===== decode_if.sv
// Carrier between the executor core and its instruction decoder
`timescale 1ns/1ps
interface decode_if;
    logic [13:0] instr;
    logic        is_copy;
    logic        is_store;
    logic        is_load;
    logic        to_file;
    logic [6:0]  faddr;
    logic [7:0]  literal;
    logic        valid;

    modport core (
        output instr,
        input  is_copy, is_store, is_load, to_file, faddr, literal, valid
    );
    modport decoder (
        input  instr,
        output is_copy, is_store, is_load, to_file, faddr, literal, valid
    );
endinterface

// ===== move_decoder.sv
// Instruction decoder for the three data-move operations
`timescale 1ns/1ps
module move_decoder (
    decode_if.decoder dec
);

    // --------------------------------------------------------------
    // Opcode match and operand extraction
    // --------------------------------------------------------------
    // Copy: 00 1000 d fffffff
    assign dec.is_copy  = (dec.instr[13:8] == move_exec_pkg::COPY_PATTERN);
    // Store: 00 0000 1 fffffff
    assign dec.is_store = (dec.instr[13:7] == move_exec_pkg::STORE_PATTERN);
    // Load: 11 00xx kkkkkkkk, bits 9:8 ignored
    assign dec.is_load  = (dec.instr[13:10] == move_exec_pkg::LOAD_PATTERN);
    assign dec.to_file  = dec.instr[move_exec_pkg::DEST_BIT];
    assign dec.faddr    = dec.instr[6:0];
    assign dec.literal  = dec.instr[7:0];
    assign dec.valid    = dec.is_copy | dec.is_store | dec.is_load;

endmodule

// ===== move_instruction_exec.sv
// Move-instruction executor with file registers behind an AHB-Lite slave
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

module move_instruction_exec (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    output logic      [7:0]  ACC_OUT,
    output logic             ZERO_FLAG_OUT,
    output logic             BUSY_OUT
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Word-aligned offset inside the map; upper address bits must be zero
    function automatic logic is_reg(input logic [31:0] addr,
                                    input logic [31:0] ofs);
        is_reg = (addr[31:2] == ofs[31:2]);
    endfunction

    // Zero detect on a data byte
    function automatic logic is_null(input logic [7:0] value);
        is_null = (value == 8'h00);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    decode_if dec ();

    move_exec_pkg::phase_t phase_q, phase_d;
    logic [13:0] instr_q,   instr_d;
    logic [7:0]  acc_q,     acc_d;
    logic        zero_q,    zero_d;
    logic        unsup_q,   unsup_d;
    logic [6:0]  fptr_q,    fptr_d;
    logic [7:0]  operand_q, operand_d;
    logic        null_q,    null_d;
    logic        busy_q,    busy_d;

    logic [31:0] addr_q,    addr_d;
    logic        write_q,   write_d;
    logic        pend_q,    pend_d;
    logic        ready_q,   ready_d;
    logic [31:0] rdata_q,   rdata_d;
    logic        resp_q;

    logic [7:0]  file_mem [move_exec_pkg::FILE_DEPTH];
    logic        mem_we;
    logic [6:0]  mem_waddr;
    logic [7:0]  mem_wdata;

    logic        capture;
    logic        access;
    logic        wr_stb;

    // ------------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------------
    assign dec.instr = instr_q;

    move_decoder u_decoder (
        .dec (dec.decoder)
    );

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------

    // Address phase accepted only for NONSEQ or SEQ while bus is ready
    assign capture = HSEL_IN & HREADY_IN & HTRANS_IN[1];
    // Data phase waits while an instruction runs, so no bus access can
    // collide with the core writing the same state
    assign access  = pend_q & (phase_q == move_exec_pkg::PH_IDLE);
    assign wr_stb  = access & write_q;

    // Next values of the bus-side state
    always_comb begin
        addr_d  = addr_q;
        write_d = write_q;
        pend_d  = pend_q;
        ready_d = ready_q;
        rdata_d = rdata_q;
        if (access) begin
            pend_d  = 1'b0;
            ready_d = 1'b1;
            if (!write_q) begin
                rdata_d = 32'h0000_0000;
                if (is_reg(addr_q, move_exec_pkg::OFS_INSTR)) begin
                    rdata_d[13:0] = instr_q;
                end else if (is_reg(addr_q, move_exec_pkg::OFS_ACC)) begin
                    rdata_d[7:0] = acc_q;
                end else if (is_reg(addr_q, move_exec_pkg::OFS_STATUS)) begin
                    rdata_d[move_exec_pkg::ZERO_BIT]  = zero_q;
                    rdata_d[move_exec_pkg::UNSUP_BIT] = unsup_q;
                end else if (is_reg(addr_q, move_exec_pkg::OFS_FPTR)) begin
                    rdata_d[6:0] = fptr_q;
                end else if (is_reg(addr_q, move_exec_pkg::OFS_FDATA)) begin
                    rdata_d[7:0] = file_mem[fptr_q];
                end
            end
        end
        // One wait state minimum keeps HREADYOUT a plain flip-flop
        if (capture) begin
            addr_d  = HADDR_IN;
            write_d = HWRITE_IN;
            pend_d  = 1'b1;
            ready_d = 1'b0;
        end
    end

    // Registers of the bus-side state
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            addr_q  <= 32'h0000_0000;
            write_q <= 1'b0;
            pend_q  <= 1'b0;
            ready_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            resp_q  <= 1'b0;
        end else begin
            addr_q  <= addr_d;
            write_q <= write_d;
            pend_q  <= pend_d;
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            resp_q  <= 1'b0;      // Always OKAY
        end
    end

    // ------------------------------------------------------------------
    // Execution core
    // ------------------------------------------------------------------

    // Four phases: decode, read, process, write to destination
    always_comb begin
        phase_d   = phase_q;
        instr_d   = instr_q;
        acc_d     = acc_q;
        zero_d    = zero_q;
        unsup_d   = unsup_q;
        fptr_d    = fptr_q;
        operand_d = operand_q;
        null_d    = null_q;
        mem_we    = 1'b0;
        mem_waddr = fptr_q;
        mem_wdata = HWDATA_IN[7:0];
        unique case (phase_q)
            move_exec_pkg::PH_IDLE: begin
                if (wr_stb) begin
                    if (is_reg(addr_q, move_exec_pkg::OFS_INSTR)) begin
                        instr_d = HWDATA_IN[13:0];
                        phase_d = move_exec_pkg::PH_Q1;
                    end else if (is_reg(addr_q, move_exec_pkg::OFS_ACC)) begin
                        acc_d = HWDATA_IN[7:0];
                    end else if (is_reg(addr_q,
                                        move_exec_pkg::OFS_STATUS)) begin
                        zero_d = HWDATA_IN[move_exec_pkg::ZERO_BIT];
                        // Write one to clear the sticky unsupported bit
                        if (HWDATA_IN[move_exec_pkg::UNSUP_BIT]) begin
                            unsup_d = 1'b0;
                        end
                    end else if (is_reg(addr_q, move_exec_pkg::OFS_FPTR)) begin
                        fptr_d = HWDATA_IN[6:0];
                    end else if (is_reg(addr_q,
                                        move_exec_pkg::OFS_FDATA)) begin
                        mem_we = 1'b1;
                    end
                end
            end
            move_exec_pkg::PH_Q1: begin
                // Other opcodes run as no-operation and are flagged
                if (!dec.valid) begin
                    unsup_d = 1'b1;
                end
                phase_d = move_exec_pkg::PH_Q2;
            end
            move_exec_pkg::PH_Q2: begin
                if (dec.is_copy) begin
                    operand_d = file_mem[dec.faddr];
                end else if (dec.is_store) begin
                    operand_d = acc_q;
                end else begin
                    operand_d = dec.literal;
                end
                phase_d = move_exec_pkg::PH_Q3;
            end
            move_exec_pkg::PH_Q3: begin
                null_d  = is_null(operand_q);
                phase_d = move_exec_pkg::PH_Q4;
            end
            move_exec_pkg::PH_Q4: begin
                mem_waddr = dec.faddr;
                mem_wdata = operand_q;
                if (dec.is_copy) begin
                    zero_d = null_q;
                    if (dec.to_file) begin
                        mem_we = 1'b1;
                    end else begin
                        acc_d = operand_q;
                    end
                end else if (dec.is_store) begin
                    mem_we = 1'b1;
                end else if (dec.is_load) begin
                    acc_d = operand_q;
                end
                phase_d = move_exec_pkg::PH_IDLE;
            end
            default: begin
                phase_d = move_exec_pkg::PH_IDLE;
            end
        endcase
        // Registered so the busy pin comes straight from a flip-flop
        busy_d = (phase_d != move_exec_pkg::PH_IDLE);
    end

    // Registers of the execution core
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            phase_q   <= move_exec_pkg::PH_IDLE;
            instr_q   <= move_exec_pkg::RST_INSTR;
            acc_q     <= move_exec_pkg::RST_ACC;
            zero_q    <= move_exec_pkg::RST_ZERO;
            unsup_q   <= 1'b0;
            fptr_q    <= move_exec_pkg::RST_FPTR;
            operand_q <= 8'h00;
            null_q    <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            phase_q   <= phase_d;
            instr_q   <= instr_d;
            acc_q     <= acc_d;
            zero_q    <= zero_d;
            unsup_q   <= unsup_d;
            fptr_q    <= fptr_d;
            operand_q <= operand_d;
            null_q    <= null_d;
            busy_q    <= busy_d;
        end
    end

    // File registers; contents undefined after reset, as in a real SRAM
    always_ff @(posedge SYS_CLK_IN) begin
        if (mem_we) begin
            file_mem[mem_waddr] <= mem_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign HRDATA_OUT    = rdata_q;
    assign HREADYOUT_OUT = ready_q;
    assign HRESP_OUT     = resp_q;
    assign ACC_OUT       = acc_q;
    assign ZERO_FLAG_OUT = zero_q;
    assign BUSY_OUT      = busy_q;

endmodule

// ===== move_instruction_exec_sva.sv
// Concurrent checks on the move executor's outputs
`timescale 1ns/1ps
module move_instruction_exec_sva (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic [7:0]  ACC_OUT,
    input  wire logic        ZERO_FLAG_OUT,
    input  wire logic        BUSY_OUT
);
    logic        busy_q;
    logic        busy_d;
    logic [13:0] ins_q;
    logic [13:0] ins_d;
    logic [7:0]  acc_q;
    logic [7:0]  acc_d;
    logic        zf_q;
    logic        zf_d;
    logic        ld;
    logic        cp;
    logic        st;

    // -------------------------------------------------------------
    // Snapshot of word and state at the start of execution
    // -------------------------------------------------------------
    // Word still held on the bus at the edge where busy is first seen
    always_comb begin
        busy_d = BUSY_OUT;
        {ins_d, acc_d, zf_d} = {ins_q, acc_q, zf_q};
        if (BUSY_OUT && !busy_q) begin
            {ins_d, acc_d, zf_d} = {HWDATA_IN[13:0], ACC_OUT, ZERO_FLAG_OUT};
        end
    end

    // Registers only
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            {busy_q, ins_q, acc_q, zf_q} <= '0;
        end else begin
            {busy_q, ins_q, acc_q, zf_q} <= {busy_d, ins_d, acc_d, zf_d};
        end
    end

    // Opcode classes of the captured word
    assign ld = ins_q[13:10] == 4'hC;
    assign cp = ins_q[13:8] == 6'h08;
    assign st = ins_q[13:7] == 7'h01;

    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    property p_len;
        $rose(BUSY_OUT) |-> BUSY_OUT[*4] ##1 !BUSY_OUT;
    endproperty
    a_len: assert property (p_len) else $error("busy length");

    property p_quiet;
        BUSY_OUT && $past(BUSY_OUT) |-> $stable(ACC_OUT);
    endproperty
    a_quiet: assert property (p_quiet) else $error("early acc");

    property p_load;
        $fell(BUSY_OUT) && ld |->
            ACC_OUT == ins_q[7:0] && ZERO_FLAG_OUT == zf_q;
    endproperty
    a_load: assert property (p_load) else $error("load result");

    property p_spare;
        $fell(BUSY_OUT) && ld && ins_q[9:8] != 2'h0 |-> ACC_OUT == ins_q[7:0];
    endproperty
    a_spare: assert property (p_spare) else $error("spare bits");

    property p_cp0;
        $fell(BUSY_OUT) && cp && !ins_q[7] |->
            ZERO_FLAG_OUT == (ACC_OUT == 8'h00);
    endproperty
    a_cp0: assert property (p_cp0) else $error("copy zero");

    property p_cp1;
        $fell(BUSY_OUT) && cp && ins_q[7] |-> ACC_OUT == acc_q;
    endproperty
    a_cp1: assert property (p_cp1) else $error("copy back acc");

    property p_st;
        $fell(BUSY_OUT) && st |-> ACC_OUT == acc_q && ZERO_FLAG_OUT == zf_q;
    endproperty
    a_st: assert property (p_st) else $error("store flags");
endmodule

bind move_instruction_exec move_instruction_exec_sva u_sva (.SYS_CLK_IN,
    .ARST_N_IN, .HWDATA_IN, .ACC_OUT, .ZERO_FLAG_OUT, .BUSY_OUT);

// ===== tb.sv
// Self-checking bench for the move-instruction executor
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [7:0]  acc;
    logic        zero;
    logic        busy;
    logic [31:0] r;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc = 0;

    move_instruction_exec u_move_instruction_exec (
        .SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .ACC_OUT(acc), .ZERO_FLAG_OUT(zero), .BUSY_OUT(busy)
    );

    // -------------------------------------------------------------
    // Clock, hang guard and closing report
    // -------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Whole run needs about 140 cycles; generous ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // -------------------------------------------------------------
    // Bus master: one single word, waits on ready, no fixed latency
    // -------------------------------------------------------------
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    task automatic wr(input logic [31:0] a, d);
        xfer(1'b1, a, d);
    endtask

    // Read stalls until any running instruction has finished
    task automatic rd(input logic [31:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_reset();
        chk("acc", 32'h0000_0000, {24'h0, acc});
        chk("flags", 32'h0000_0000, {30'h0, zero, busy});
        rd(move_exec_pkg::OFS_STATUS);
        chk("status", 32'h0000_0000, r);
        rd(32'h0000_0040);
        chk("unmapped", 32'h0000_0000, r);
        $display("t_reset done");
    endtask

    // Every spare-bit pattern, zero flag preset to both levels
    task automatic t_load();
        logic [7:0] k;
        for (int s = 0; s < 4; s++) begin
            k = 8'hA5 ^ 8'(s);
            wr(move_exec_pkg::OFS_STATUS, {31'h0, s[0]});
            wr(move_exec_pkg::OFS_INSTR, {18'h0, 4'hC, s[1:0], k});
            rd(move_exec_pkg::OFS_STATUS);
            chk("load acc", {24'h0, k}, {24'h0, acc});
            chk("load status", {31'h0, s[0]}, r);
        end
        $display("t_load done");
    endtask

    task automatic t_store();
        wr(move_exec_pkg::OFS_ACC, 32'h0000_004F);
        wr(move_exec_pkg::OFS_STATUS, 32'h0000_0001);
        wr(move_exec_pkg::OFS_FPTR, 32'h0000_0025);
        wr(move_exec_pkg::OFS_FDATA, 32'h0000_00FF);
        wr(move_exec_pkg::OFS_INSTR, {18'h0, 7'h01, 7'h25});
        rd(move_exec_pkg::OFS_FDATA);
        chk("store file", 32'h0000_004F, r);
        chk("store zero", 32'h0000_0001, {31'h0, zero});
        chk("store acc", 32'h0000_004F, {24'h0, acc});
        $display("t_store done");
    endtask

    // Top register address, nonzero then zero value, both targets
    task automatic t_copy();
        wr(move_exec_pkg::OFS_FPTR, 32'h0000_007F);
        wr(move_exec_pkg::OFS_FDATA, 32'h0000_0080);
        wr(move_exec_pkg::OFS_ACC, 32'h0000_0033);
        wr(move_exec_pkg::OFS_STATUS, 32'h0000_0001);
        wr(move_exec_pkg::OFS_INSTR, {18'h0, 6'h08, 1'b0, 7'h7F});
        rd(move_exec_pkg::OFS_FDATA);
        chk("copy file", 32'h0000_0080, r);
        chk("copy acc", 32'h0000_0080, {24'h0, acc});
        chk("copy zero", 32'h0000_0000, {31'h0, zero});
        wr(move_exec_pkg::OFS_FDATA, 32'h0000_0000);
        wr(move_exec_pkg::OFS_INSTR, {18'h0, 6'h08, 1'b1, 7'h7F});
        rd(move_exec_pkg::OFS_FDATA);
        chk("test file", 32'h0000_0000, r);
        chk("test acc", 32'h0000_0080, {24'h0, acc});
        chk("test zero", 32'h0000_0001, {31'h0, zero});
        $display("t_copy done");
    endtask

    // Foreign opcode runs as no-op; sticky flag, write one to clear
    task automatic t_unsup();
        wr(move_exec_pkg::OFS_ACC, 32'h0000_005A);
        wr(move_exec_pkg::OFS_STATUS, 32'h0000_0000);
        wr(move_exec_pkg::OFS_INSTR, 32'h0000_3835);
        rd(move_exec_pkg::OFS_STATUS);
        chk("unsup set", 32'h0000_0004, r);
        rd(move_exec_pkg::OFS_ACC);
        chk("unsup acc", 32'h0000_005A, r);
        rd(move_exec_pkg::OFS_INSTR);
        chk("instr back", 32'h0000_3835, r);
        rd(move_exec_pkg::OFS_FPTR);
        chk("fptr back", 32'h0000_007F, r);
        wr(move_exec_pkg::OFS_STATUS, 32'h0000_0004);
        rd(move_exec_pkg::OFS_STATUS);
        chk("unsup clear", 32'h0000_0000, r);
        $display("t_unsup done");
    endtask

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_load();
        t_store();
        t_copy();
        t_unsup();
        give_verdict();
    end
endmodule
